// ==== rtl/ata_consts.svh ====
// Task-file addresses, bit positions, codes and limits
`ifndef ATA_CONSTS_SVH
`define ATA_CONSTS_SVH
`define TF_FEAT 3'h1
`define TF_COUNT 3'h2
`define TF_SECNUM 3'h3
`define TF_CYLLO 3'h4
`define TF_CYLHI 3'h5
`define TF_DRVHD 3'h6
`define TF_CMD 3'h7
`define ST_BSY 7
`define ST_DRDY 6
`define ST_DRQ 3
`define ST_ERR 0
`define ER_ABRT 8'h04
`define ER_WFAIL 8'h40
`define CMD_WR_SECT 8'h30
`define CMD_WR_SECT_NE 8'h38
`define CMD_WR_MULT 8'hC5
`define CMD_WR_MULT_NE 8'hCD
`define CMD_SET_MULT 8'hC6
`define CMD_SMART 8'hB0
`define FT_RD_DATA 8'hD0
`define FT_RD_THR 8'hD1
`define FT_AUTOSAVE 8'hD2
`define FT_SAVE 8'hD3
`define FT_OFFLINE 8'hD4
`define FT_ENABLE 8'hD8
`define FT_DISABLE 8'hD9
`define FT_STATUS 8'hDA
`define SIG_LO 8'h4F
`define SIG_HI 8'hC2
`define SIG_BAD_LO 8'hF4
`define SIG_BAD_HI 8'h2C
`define DH_WRITE 8'hA0
`define DH_SMART 8'hE0
`define DH_LBA 6
`define DH_DEV 4
`define MAX_BLOCK 8'h01
`define SECTOR_WORDS 256
`define HR_CTRL 4'h0
`define HR_CMD 4'h1
`define HR_FEAT 4'h2
`define HR_COUNT 4'h3
`define HR_LBA0 4'h4
`define HR_LBA1 4'h5
`define HR_LBA2 4'h6
`define HR_DRVHD 4'h7
`define HR_STAT 4'h8
`define HR_DSTAT 4'h9
`define HR_DERR 4'hA
`endif

// ==== rtl/ata_pkg.sv ====
// Types shared by both ends of the task-file link
package ata_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic [3:0] {
		DV_IDLE = 4'b0001,
		DV_ACCEPT = 4'b0010,
		DV_XFER = 4'b0100,
		DV_PROG = 4'b1000
	} dev_state_t;
	typedef enum logic [4:0] {
		HS_IDLE = 5'b00001,
		HS_LOAD = 5'b00010,
		HS_POLL = 5'b00100,
		HS_DATA = 5'b01000,
		HS_ERRRD = 5'b10000
	} host_state_t;
endpackage

// ==== rtl/ata_link_if.sv ====
// Task-file link between host controller and drive
`timescale 1ns/1ns
interface ata_link_if;
	logic [2:0] tf_addr;
	logic [7:0] tf_wdata;
	logic tf_wr;
	logic tf_rd;
	logic [7:0] tf_rdata;
	logic [15:0] dat_wdata;
	logic dat_wr;
	logic intrq;
	modport dev (input tf_addr, tf_wdata, tf_wr, tf_rd, dat_wdata, dat_wr,
		output tf_rdata, intrq);
	modport host (output tf_addr, tf_wdata, tf_wr, tf_rd, dat_wdata, dat_wr,
		input tf_rdata, intrq);
endinterface

// ==== rtl/ata_write_dev.sv ====
// Drive end: write-sector, block-write and SMART command decoder
`timescale 1ns/1ns
`include "ata_consts.svh"
module ata_write_dev import ata_pkg::*; #(
	parameter int SECTOR_WORDS = `SECTOR_WORDS
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Host link
	ata_link_if.dev link,
	// Sector data and flash programming
	output logic buf_wr,
	output logic [15:0] buf_data,
	output logic prog_req,
	output logic [27:0] prog_lba,
	output logic prog_erase,
	input wire logic prog_done,
	input wire logic prog_fail,
	input wire logic sector_erased,
	// SMART state and operations
	input wire logic smart_nv_in,
	input wire logic threshold_exceeded,
	output logic smart_en,
	output logic smart_save,
	output logic smart_op,
	output byte_t smart_feat
);
	localparam int WW = $clog2(SECTOR_WORDS);
	if (SECTOR_WORDS < 2 || SECTOR_WORDS > 65536)
		$error("SECTOR_WORDS out of range");

	function automatic logic [27:0] lba_of(byte_t dh, byte_t ch, byte_t cl,
		byte_t sn);
		lba_of = {dh[3:0], ch, cl, sn};
	endfunction

	dev_state_t state_reg;
	byte_t feat_reg, count_reg, secnum_reg, cyllo_reg, cylhi_reg, dh_reg;
	byte_t err_reg, mult_reg, rdata_reg;
	logic bsy_reg, drq_reg, st_err_reg, intrq_reg, nowipe_reg, loaded_reg;
	logic [8:0] remain_reg;
	logic [WW-1:0] word_reg;
	logic cmd_wr, regs_wr, is_write, is_mult, abort_c, quick_c, smart_ok;
	logic last_word, prog_ok, prog_bad, more_c, irq_set, smart_c;

	assign link.tf_rdata = rdata_reg;
	assign link.intrq = intrq_reg;

	// Command decode
	always_comb begin
		cmd_wr = link.tf_wr && link.tf_addr == `TF_CMD && state_reg == DV_IDLE;
		regs_wr = link.tf_wr && link.tf_addr != `TF_CMD &&
			state_reg == DV_IDLE;
		is_mult = link.tf_wdata == `CMD_WR_MULT ||
			link.tf_wdata == `CMD_WR_MULT_NE;
		is_write = is_mult || link.tf_wdata == `CMD_WR_SECT ||
			link.tf_wdata == `CMD_WR_SECT_NE;
		smart_c = link.tf_wdata == `CMD_SMART;
		smart_ok = cylhi_reg == `SIG_HI && cyllo_reg == `SIG_LO &&
			(smart_en || feat_reg == `FT_ENABLE);
		case (feat_reg)
			`FT_RD_DATA, `FT_RD_THR, `FT_AUTOSAVE, `FT_SAVE, `FT_OFFLINE,
			`FT_ENABLE, `FT_DISABLE, `FT_STATUS: ;
			default: smart_ok = 1'b0;
		endcase
		abort_c = 1'b0;
		quick_c = 1'b0;
		if (is_write)
			abort_c = is_mult && mult_reg == 8'h00;
		else if (link.tf_wdata == `CMD_SET_MULT) begin
			abort_c = count_reg > `MAX_BLOCK;
			quick_c = !abort_c;
		end else if (smart_c) begin
			abort_c = !smart_ok;
			quick_c = smart_ok;
		end else
			abort_c = 1'b1;
		abort_c = cmd_wr && abort_c;
		quick_c = cmd_wr && quick_c;
		last_word = state_reg == DV_XFER && link.dat_wr &&
			word_reg == WW'(SECTOR_WORDS - 1);
		prog_ok = state_reg == DV_PROG && prog_done && !prog_fail;
		prog_bad = state_reg == DV_PROG && prog_done && prog_fail;
		more_c = remain_reg != 9'h001;
		irq_set = abort_c || quick_c || prog_done && state_reg == DV_PROG;
	end

	// Protocol state, status bits and error register
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= DV_IDLE;
			bsy_reg <= 1'b0;
			drq_reg <= 1'b0;
			st_err_reg <= 1'b0;
			err_reg <= 8'h00;
			remain_reg <= 9'h000;
			nowipe_reg <= 1'b0;
		end else begin
			case (state_reg)
				DV_IDLE: begin
					if (abort_c) begin
						st_err_reg <= 1'b1;
						err_reg <= `ER_ABRT;
					end else if (cmd_wr) begin
						st_err_reg <= 1'b0;
						err_reg <= 8'h00;
						if (is_write) begin
							state_reg <= DV_ACCEPT;
							bsy_reg <= 1'b1;
							remain_reg <= (count_reg == 8'h00) ? 9'h100 :
								{1'b0, count_reg};
							nowipe_reg <= link.tf_wdata == `CMD_WR_SECT_NE ||
								link.tf_wdata == `CMD_WR_MULT_NE;
						end
					end
				end
				DV_ACCEPT: begin
					state_reg <= DV_XFER;
					bsy_reg <= 1'b0;
					drq_reg <= 1'b1;
				end
				DV_XFER: begin
					if (last_word) begin
						state_reg <= DV_PROG;
						bsy_reg <= 1'b1;
						drq_reg <= 1'b0;
					end
				end
				DV_PROG: begin
					if (prog_bad) begin
						state_reg <= DV_IDLE;
						bsy_reg <= 1'b0;
						st_err_reg <= 1'b1;
						err_reg <= `ER_WFAIL;
					end else if (prog_ok && more_c) begin
						state_reg <= DV_XFER;
						bsy_reg <= 1'b0;
						drq_reg <= 1'b1;
						remain_reg <= remain_reg - 9'h001;
					end else if (prog_ok) begin
						state_reg <= DV_IDLE;
						bsy_reg <= 1'b0;
					end
				end
				default: begin
					state_reg <= DV_IDLE;
					bsy_reg <= 1'b0;
					drq_reg <= 1'b0;
				end
			endcase
		end
	end

	// Task-file registers
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			feat_reg <= 8'h00;
			count_reg <= 8'h00;
			secnum_reg <= 8'h00;
			cyllo_reg <= 8'h00;
			cylhi_reg <= 8'h00;
			dh_reg <= 8'h00;
		end else if (regs_wr) begin
			case (link.tf_addr)
				`TF_FEAT: feat_reg <= link.tf_wdata;
				`TF_COUNT: count_reg <= link.tf_wdata;
				`TF_SECNUM: secnum_reg <= link.tf_wdata;
				`TF_CYLLO: cyllo_reg <= link.tf_wdata;
				`TF_CYLHI: cylhi_reg <= link.tf_wdata;
				default: dh_reg <= link.tf_wdata;
			endcase
		end else if (quick_c && smart_c && feat_reg == `FT_STATUS) begin
			cyllo_reg <= threshold_exceeded ? `SIG_BAD_LO : `SIG_LO;
			cylhi_reg <= threshold_exceeded ? `SIG_BAD_HI : `SIG_HI;
		end else if (prog_ok && more_c) begin
			{dh_reg[3:0], cylhi_reg, cyllo_reg, secnum_reg} <=
				lba_of(dh_reg, cylhi_reg, cyllo_reg, secnum_reg) +
				28'h0000001;
			count_reg <= 8'(remain_reg - 9'h001);
		end else if (prog_done && state_reg == DV_PROG) begin
			count_reg <= prog_fail ? 8'(remain_reg) : 8'h00;
		end
	end

	// Block size from the set-multiple command
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			mult_reg <= 8'h00;
		else if (quick_c && link.tf_wdata == `CMD_SET_MULT)
			mult_reg <= count_reg;
	end

	// Sector words to the buffer, then one program request
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			word_reg <= '0;
			buf_wr <= 1'b0;
			buf_data <= 16'h0000;
			prog_req <= 1'b0;
			prog_lba <= 28'h0000000;
			prog_erase <= 1'b0;
		end else begin
			buf_wr <= 1'b0;
			prog_req <= last_word;
			if (state_reg == DV_XFER && link.dat_wr) begin
				buf_wr <= 1'b1;
				buf_data <= link.dat_wdata;
				word_reg <= last_word ? '0 : word_reg + 1'b1;
			end
			if (last_word) begin
				prog_lba <= lba_of(dh_reg, cylhi_reg, cyllo_reg,
					secnum_reg);
				prog_erase <= !(nowipe_reg && sector_erased);
			end
		end
	end

	// SMART enable, restored from nonvolatile copy after reset
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			loaded_reg <= 1'b0;
			smart_en <= 1'b0;
			smart_save <= 1'b0;
			smart_op <= 1'b0;
			smart_feat <= 8'h00;
		end else begin
			loaded_reg <= 1'b1;
			smart_save <= 1'b0;
			smart_op <= 1'b0;
			if (!loaded_reg)
				smart_en <= smart_nv_in;
			else if (quick_c && smart_c) begin
				smart_op <= 1'b1;
				smart_feat <= feat_reg;
				if (feat_reg == `FT_ENABLE || feat_reg == `FT_DISABLE) begin
					smart_en <= feat_reg == `FT_ENABLE;
					smart_save <= 1'b1;
				end
			end
		end
	end

	// Interrupt: set wins over clear by status read or command
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			intrq_reg <= 1'b0;
		else if (irq_set)
			intrq_reg <= 1'b1;
		else if ((link.tf_rd || link.tf_wr) && link.tf_addr == `TF_CMD)
			intrq_reg <= 1'b0;
	end

	// Register read, data in the following cycle
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			rdata_reg <= 8'h00;
		else if (link.tf_rd) begin
			case (link.tf_addr)
				`TF_FEAT: rdata_reg <= err_reg;
				`TF_COUNT: rdata_reg <= count_reg;
				`TF_SECNUM: rdata_reg <= secnum_reg;
				`TF_CYLLO: rdata_reg <= cyllo_reg;
				`TF_CYLHI: rdata_reg <= cylhi_reg;
				`TF_DRVHD: rdata_reg <= dh_reg;
				`TF_CMD: rdata_reg <= {bsy_reg, !bsy_reg, 2'b00, drq_reg,
					2'b00, st_err_reg};
				default: rdata_reg <= 8'h00;
			endcase
		end
	end
endmodule

// ==== rtl/ata_write_host.sv ====
// Host end: loads the task file, polls status, streams sector data
`timescale 1ns/1ns
`include "ata_consts.svh"
module ata_write_host import ata_pkg::*; #(
	parameter int SECTOR_WORDS = `SECTOR_WORDS
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Drive link
	ata_link_if.host link,
	// Software register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output byte_t reg_rdata,
	// Sector data source
	input wire logic src_valid,
	input wire logic [15:0] src_data,
	output logic src_ready
);
	localparam int WW = $clog2(SECTOR_WORDS);
	if (SECTOR_WORDS < 2 || SECTOR_WORDS > 65536)
		$error("SECTOR_WORDS out of range");

	host_state_t state_reg;
	byte_t cmd_reg, feat_reg, count_reg, lba0_reg, lba1_reg, lba2_reg;
	byte_t dh_reg, dstat_reg, derr_reg, tfv;
	logic done_reg, rd_pipe_reg;
	logic [2:0] idx_reg;
	logic [WW-1:0] word_reg;
	logic busy, take, smart;

	assign busy = state_reg != HS_IDLE;
	assign take = state_reg == HS_DATA && src_valid && src_ready;
	assign smart = cmd_reg == `CMD_SMART;

	// Task-file value for each address in load order
	always_comb begin
		case (idx_reg)
			`TF_FEAT: tfv = feat_reg;
			`TF_COUNT: tfv = count_reg;
			`TF_SECNUM: tfv = lba0_reg;
			`TF_CYLLO: tfv = smart ? `SIG_LO : lba1_reg;
			`TF_CYLHI: tfv = smart ? `SIG_HI : lba2_reg;
			`TF_DRVHD: tfv = smart ? (`DH_SMART | (dh_reg & 8'h10)) :
				(`DH_WRITE | (dh_reg & 8'h5F));
			default: tfv = cmd_reg;
		endcase
	end

	// Software registers
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_reg <= 8'h00;
			feat_reg <= 8'h00;
			count_reg <= 8'h00;
			lba0_reg <= 8'h00;
			lba1_reg <= 8'h00;
			lba2_reg <= 8'h00;
			dh_reg <= 8'h00;
			reg_rdata <= 8'h00;
		end else begin
			if (reg_wr && !busy) begin
				case (reg_addr)
					`HR_CMD: cmd_reg <= reg_wdata;
					`HR_FEAT: feat_reg <= reg_wdata;
					`HR_COUNT: count_reg <= reg_wdata;
					`HR_LBA0: lba0_reg <= reg_wdata;
					`HR_LBA1: lba1_reg <= reg_wdata;
					`HR_LBA2: lba2_reg <= reg_wdata;
					`HR_DRVHD: dh_reg <= reg_wdata;
					default: ;
				endcase
			end
			if (reg_rd) begin
				case (reg_addr)
					`HR_STAT: reg_rdata <= {6'h00, done_reg, busy};
					`HR_DSTAT: reg_rdata <= dstat_reg;
					`HR_DERR: reg_rdata <= derr_reg;
					default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// Command sequencer
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= HS_IDLE;
			idx_reg <= 3'h1;
			word_reg <= '0;
			done_reg <= 1'b0;
			dstat_reg <= 8'h00;
			derr_reg <= 8'h00;
			rd_pipe_reg <= 1'b0;
			link.tf_addr <= 3'h0;
			link.tf_wdata <= 8'h00;
			link.tf_wr <= 1'b0;
			link.tf_rd <= 1'b0;
			link.dat_wr <= 1'b0;
			link.dat_wdata <= 16'h0000;
			src_ready <= 1'b0;
		end else begin
			link.tf_wr <= 1'b0;
			link.tf_rd <= 1'b0;
			link.dat_wr <= 1'b0;
			rd_pipe_reg <= link.tf_rd;
			case (state_reg)
				HS_IDLE: begin
					if (reg_wr && reg_addr == `HR_CTRL && reg_wdata[0]) begin
						state_reg <= HS_LOAD;
						idx_reg <= 3'h1;
						done_reg <= 1'b0;
						derr_reg <= 8'h00;
					end
				end
				HS_LOAD: begin
					link.tf_wr <= 1'b1;
					link.tf_addr <= idx_reg;
					link.tf_wdata <= tfv;
					idx_reg <= idx_reg + 3'h1;
					if (idx_reg == `TF_CMD)
						state_reg <= HS_POLL;
				end
				HS_POLL: begin
					if (rd_pipe_reg) begin
						dstat_reg <= link.tf_rdata;
						if (link.tf_rdata[`ST_BSY]) begin
						end else if (link.tf_rdata[`ST_DRQ]) begin
							state_reg <= HS_DATA;
							word_reg <= '0;
							src_ready <= 1'b1;
						end else if (link.tf_rdata[`ST_ERR]) begin
							state_reg <= HS_ERRRD;
						end else begin
							state_reg <= HS_IDLE;
							done_reg <= 1'b1;
						end
					end else if (!link.tf_rd) begin
						link.tf_rd <= 1'b1;
						link.tf_addr <= `TF_CMD;
					end
				end
				HS_DATA: begin
					if (take) begin
						link.dat_wr <= 1'b1;
						link.dat_wdata <= src_data;
						word_reg <= word_reg + 1'b1;
						if (word_reg == WW'(SECTOR_WORDS - 1)) begin
							state_reg <= HS_POLL;
							src_ready <= 1'b0;
						end
					end
				end
				HS_ERRRD: begin
					if (rd_pipe_reg) begin
						derr_reg <= link.tf_rdata;
						state_reg <= HS_IDLE;
						done_reg <= 1'b1;
					end else if (!link.tf_rd) begin
						link.tf_rd <= 1'b1;
						link.tf_addr <= `TF_FEAT;
					end
				end
				default: state_reg <= HS_IDLE;
			endcase
		end
	end
endmodule

// ==== testbench/ata_link_asserts.sv ====
// Protocol checks on the task-file link between host and drive ends
`timescale 1ns/1ns
`include "ata_consts.svh"
module ata_link_asserts import ata_pkg::*; #(
	parameter int SECTOR_WORDS = `SECTOR_WORDS
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Task-file link
	input wire logic [2:0] tf_addr,
	input wire logic [7:0] tf_wdata,
	input wire logic tf_wr,
	input wire logic tf_rd,
	input wire logic [7:0] tf_rdata,
	input wire logic [15:0] dat_wdata,
	input wire logic dat_wr,
	input wire logic intrq
);
	logic [7:0] feat_reg, cyllo_reg, cylhi_reg, dh_reg;
	int word_reg;
	logic cmd_wr, wr_cmd, bad_cmd, sect_cmd, wait_first;
	assign cmd_wr = tf_wr && tf_addr == `TF_CMD;
	assign sect_cmd = tf_wdata inside {`CMD_WR_SECT, `CMD_WR_SECT_NE};
	assign wr_cmd = tf_wdata inside {`CMD_WR_SECT, `CMD_WR_SECT_NE,
		`CMD_WR_MULT, `CMD_WR_MULT_NE};
	assign bad_cmd = !(wr_cmd || tf_wdata inside {`CMD_SET_MULT, `CMD_SMART})
		|| (tf_wdata == `CMD_SMART && !(feat_reg inside {[8'hD0:8'hD4],
		[8'hD8:8'hDA]}));
	// Last value the host loaded into the feature, cylinder low/high and drive/head registers
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			feat_reg <= 8'h00;
			cyllo_reg <= 8'h00;
			cylhi_reg <= 8'h00;
			dh_reg <= 8'h00;
		end else if (tf_wr) begin
			case (tf_addr)
				`TF_FEAT: feat_reg <= tf_wdata;
				`TF_CYLLO: cyllo_reg <= tf_wdata;
				`TF_CYLHI: cylhi_reg <= tf_wdata;
				`TF_DRVHD: dh_reg <= tf_wdata;
				default: ;
			endcase
		end
	end
	// Word position inside the current sector
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			word_reg <= 0;
		else if (cmd_wr)
			word_reg <= 0;
		else if (dat_wr)
			word_reg <= (word_reg == SECTOR_WORDS - 1) ? 0 : word_reg + 1;
	end
	// From a sector write command until its first data word
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			wait_first <= 1'b0;
		else if (cmd_wr && sect_cmd)
			wait_first <= 1'b1;
		else if (dat_wr)
			wait_first <= 1'b0;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	a_no_first_intr: assert property (wait_first |-> !intrq)
		else $error("interrupt before first word");
	a_first_data: assert property (
		cmd_wr && sect_cmd |=> ##[0:60] dat_wr)
		else $error("no data after write command");
	a_data_after_cmd: assert property (cmd_wr |=> !dat_wr [*2])
		else $error("data word while drive busy");
	a_sector_gap: assert property (
		dat_wr && word_reg == SECTOR_WORDS - 1 |=> !dat_wr [*2])
		else $error("no busy gap after sector");
	a_load_order: assert property (
		cmd_wr |-> $past(tf_wr) && $past(tf_addr) == `TF_DRVHD)
		else $error("command not preceded by address load");
	a_write_dh: assert property (
		cmd_wr && wr_cmd |-> dh_reg[7] && dh_reg[5])
		else $error("drive/head fixed bits wrong");
	a_smart_sig: assert property (cmd_wr && tf_wdata == `CMD_SMART |->
		cylhi_reg == `SIG_HI && cyllo_reg == `SIG_LO && dh_reg[7:5] == 3'b111)
		else $error("smart signature missing");
	a_abort_intr: assert property (cmd_wr && bad_cmd |=> ##[0:4] intrq)
		else $error("abort without interrupt");
	a_rdata_hold: assert property (!tf_rd |=> $stable(tf_rdata))
		else $error("read data changed without read");
endmodule

// ==== testbench/ata_write_and_smart_cmd_decoder_tb_top.sv ====
// Self-checking bench joining host and drive ends of the task-file link
`timescale 1ns/1ns
`include "ata_consts.svh"
module ata_write_and_smart_cmd_decoder_tb_top import ata_pkg::*;;
	localparam int SW = 4;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	byte_t reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic src_valid = 1'b0;
	logic [15:0] src_data = 16'h0000;
	logic prog_done = 1'b0;
	logic prog_fail = 1'b0;
	logic sector_erased = 1'b0;
	logic smart_nv_in = 1'b1;
	logic thr = 1'b0;
	byte_t reg_rdata, smart_feat, efeat;
	logic src_ready, buf_wr, prog_req, prog_erase, smart_en, smart_save, smart_op;
	logic [15:0] buf_data;
	logic [27:0] prog_lba, exp_lba;
	logic exp_erase, sen, ethr;
	logic [15:0] wq[$];
	byte_t ft[10] = '{8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hDA, 8'hD9, 8'hD0,
		8'hD8, 8'hD5};
	int failures = 0;
	int num_checks = 0;
	int seed = 32'hCB8D;
	int nprog, nsm, nsv, esv, fail_at, dly, k;
	always #5 mclk = ~mclk;
	ata_link_if link();
	ata_write_host #(.SECTOR_WORDS(SW)) u_ata_write_host (.mclk(mclk),
		.rst_b(rst_b), .link(link), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.src_valid(src_valid), .src_data(src_data), .src_ready(src_ready));
	ata_write_dev #(.SECTOR_WORDS(SW)) u_ata_write_dev (.mclk(mclk),
		.rst_b(rst_b), .link(link), .buf_wr(buf_wr), .buf_data(buf_data),
		.prog_req(prog_req), .prog_lba(prog_lba), .prog_erase(prog_erase),
		.prog_done(prog_done), .prog_fail(prog_fail),
		.sector_erased(sector_erased), .smart_nv_in(smart_nv_in),
		.threshold_exceeded(thr), .smart_en(smart_en), .smart_save(smart_save),
		.smart_op(smart_op), .smart_feat(smart_feat));
	ata_link_asserts #(.SECTOR_WORDS(SW)) u_ata_link_asserts (.mclk(mclk),
		.rst_b(rst_b), .tf_addr(link.tf_addr), .tf_wdata(link.tf_wdata),
		.tf_wr(link.tf_wr), .tf_rd(link.tf_rd), .tf_rdata(link.tf_rdata),
		.dat_wdata(link.dat_wdata), .dat_wr(link.dat_wr), .intrq(link.intrq));
	// Command block as the drive holds it
	logic [27:0] dev_lba;
	logic [15:0] dev_cyl;
	assign dev_cyl = {u_ata_write_dev.cylhi_reg, u_ata_write_dev.cyllo_reg};
	assign dev_lba = {u_ata_write_dev.dh_reg[3:0], dev_cyl,
		u_ata_write_dev.secnum_reg};
	task automatic finish_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk_val(input logic [31:0] got, exp, input string m);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic chk_cnt(input int got, exp, input string m);
		num_checks++;
		if (got != exp) begin
			failures++;
			$display("BAD %0t %s got %0d exp %0d", $time, m, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input byte_t d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [3:0] a, output byte_t d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(posedge mclk);
		d = reg_rdata;
	endtask
	// Data source, flash responder and result model
	always @(posedge mclk) begin
		prog_done <= 1'b0;
		prog_fail <= 1'b0;
		thr <= 1'($random(seed));
		if (link.tf_wr && link.tf_addr == `TF_CMD) ethr = thr;
		if (src_valid && src_ready) wq.push_back(src_data);
		if (!src_valid || src_ready) begin
			src_valid <= ($random(seed) & 3) != 0;
			src_data <= 16'($random(seed));
		end
		if (buf_wr) chk_val(buf_data, wq.pop_front(), "word");
		if (smart_op) begin
			nsm++;
			chk_val(smart_feat, efeat, "feature");
		end
		if (smart_save) nsv++;
		if (prog_req) begin
			nprog++;
			chk_val({prog_erase, prog_lba}, {exp_erase, exp_lba}, "prog");
			exp_lba++;
			dly = 2 + {$random(seed)} % 6;
		end else if (dly > 0) begin
			dly--;
			if (dly == 0) begin
				prog_done <= 1'b1;
				prog_fail <= nprog == fail_at;
			end
		end
	end
	task automatic go(input byte_t c, f, n, input logic [27:0] a,
		input int en, input byte_t er);
		byte_t d;
		int i;
		logic [31:0] e_lba, e_cnt;
		exp_lba = a;
		efeat = f;
		nprog = 0;
		nsm = 0;
		wr(`HR_CMD, c);
		exp_erase = !(c inside {`CMD_WR_SECT_NE, `CMD_WR_MULT_NE}) ||
			!sector_erased;
		wr(`HR_FEAT, f);
		wr(`HR_COUNT, n);
		wr(`HR_LBA0, a[7:0]);
		wr(`HR_LBA1, a[15:8]);
		wr(`HR_LBA2, a[23:16]);
		wr(`HR_DRVHD, {4'hE, a[27:24]});
		wr(`HR_CTRL, 8'h01);
		for (i = 0; i < 9000; i++) begin
			rd(`HR_STAT, d);
			if (d[1] && !d[0]) break;
		end
		if (i == 9000) begin
			failures++;
			$display("BAD %0t command hung", $time);
			finish_test();
		end
		chk_cnt(nprog, en, "sectors");
		chk_cnt(nsm, c == `CMD_SMART && er == 8'h00, "smart ops");
		if (c == `CMD_SMART && er == 8'h00 &&
			f inside {`FT_ENABLE, `FT_DISABLE}) begin
			esv += sen != (f == `FT_ENABLE);
			sen = f == `FT_ENABLE;
		end
		chk_val(smart_en, sen, "smart state");
		// Last or failing sector stays in the command block
		e_lba = a + ((en > 0) ? en - 1 : 0);
		e_cnt = (er == `ER_WFAIL) ? n - en + 1 : (en > 0) ? 0 : n;
		if (c != `CMD_SMART) begin
			chk_val(dev_lba, e_lba, "address");
			chk_val(u_ata_write_dev.count_reg, e_cnt, "count");
		end else if (f == `FT_STATUS && er == 8'h00)
			chk_val(dev_cyl, ethr ? 16'h2CF4 : 16'hC24F, "status");
		rd(`HR_DSTAT, d);
		chk_val(d[`ST_ERR], er != 8'h00, "err bit");
		if (er != 8'h00) begin
			rd(`HR_DERR, d);
			chk_val(d, er, "error code");
		end
	endtask
	initial begin
		sen = 1'b1;
		esv = 0;
		fail_at = 0;
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		go(`CMD_WR_SECT, 8'h00, 8'h02, 28'h00000FF, 2, 8'h00);
		go(`CMD_WR_MULT_NE, 8'h00, 8'h01, 28'h0000010, 0, `ER_ABRT);
		go(`CMD_SET_MULT, 8'h00, 8'h02, 28'h0000000, 0, `ER_ABRT);
		go(`CMD_SET_MULT, 8'h00, `MAX_BLOCK, 28'h0000000, 0, 8'h00);
		sector_erased <= 1'b1;
		go(`CMD_WR_MULT_NE, 8'h00, 8'h03, 28'hABCDEFE, 3, 8'h00);
		go(`CMD_WR_MULT, 8'h00, 8'h01, 28'h0123456, 1, 8'h00);
		go(`CMD_WR_SECT_NE, 8'h00, 8'h02, 28'h0000100, 2, 8'h00);
		sector_erased <= 1'b0;
		go(`CMD_WR_SECT_NE, 8'h00, 8'h01, 28'h0000200, 1, 8'h00);
		fail_at = 2;
		go(`CMD_WR_SECT, 8'h00, 8'h03, 28'h0000300, 2, `ER_WFAIL);
		fail_at = 0;
		go(8'h55, 8'h00, 8'h01, 28'h0000000, 0, `ER_ABRT);
		go(`CMD_WR_SECT, 8'h00, 8'h00, 28'h0FFFF80, 256, 8'h00);
		for (k = 0; k < 10; k++)
			go(`CMD_SMART, ft[k], 8'h00, 28'h0000000, 0,
				(k == 7 || k == 9) ? `ER_ABRT : 8'h00);
		chk_cnt(nsv, esv, "nv saves");
		rst_b <= 1'b0;
		smart_nv_in <= 1'b0;
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		sen = 1'b0;
		go(`CMD_SMART, `FT_STATUS, 8'h00, 28'h0000000, 0, `ER_ABRT);
		finish_test();
	end
endmodule
